// ==== dv/ais_sequencer_tb.sv ====
// Purpose: Self-checking bench of the injection sequencer
// Assumes: CONV_CYC kept at 16, so a start taken at lag 15 hits the last cycle
// Notes:   Hazard test runs last; a second reset frees the blocked converter
`timescale 1ns/10ps
`include "ais_defines.svh"
module ais_sequencer_tb;
    localparam int CC = 16;
    logic              ref_clk     = 1'b0;
    logic              reset       = 1'b1;
    ais_pkg::ais_bus_t bus         = '0;
    logic [9:0]        level       = 10'h000;
    logic [31:0]       rdata;
    logic              inj_req;
    logic [9:0]        conv_sample;
    logic [3:0]        conv_channel;
    logic              irq;
    int                errors      = 0;
    int                check_count = 0;
    int                cycles      = 0;
    logic [31:0]       d;
    logic [31:0]       kept;
    logic [31:0]       exp_res[$];

    always #25 ref_clk = ~ref_clk;

    ais_sequencer #(.DW(10), .CONV_CYC(CC)) dut (.ref_clk(ref_clk), .reset(reset), .bus(bus), .rdata(rdata),
        .inj_req(inj_req), .conv_sample(conv_sample), .conv_channel(conv_channel), .irq(irq));
    ais_trig_model u_trig (.ref_clk(ref_clk), .level(level), .inj_req(inj_req), .conv_sample(conv_sample));

    // ****************************************
    // Bus, compare and closing tasks
    // ****************************************
    task automatic complete_run();
        if (errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(logic [7:0] a, logic [31:0] v);
        @(posedge ref_clk);
        bus.addr  <= a;
        bus.wdata <= v;
        bus.wr    <= 1'b1;
        @(posedge ref_clk);
        bus.wr    <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(logic [7:0] a);
        @(posedge ref_clk);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge ref_clk);
        bus.rd   <= 1'b0;
        #1 d = rdata;
    endtask : rd

    // Looks just after each edge so a flag cleared at that edge is not seen stale
    task automatic wait_irq(int n);
        int i;
        i = 0;
        #1;
        while (irq !== 1'b1 && i < n) begin
            @(posedge ref_clk);
            #1;
            i++;
        end
        chk("irq", 32'h1, {31'h0, irq});
    endtask : wait_irq

    task automatic inj_start(int lag, logic [31:0] ctrl);
        u_trig.fire();
        repeat (lag) @(posedge ref_clk);
        wr(`AIS_CTRL_OFS, ctrl);
    endtask : inj_start

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        void'($urandom(55));
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        for (int a = 0; a <= 24; a += 4) begin
            rd(a[7:0]);
            chk("reset_reg", 32'h0, d);
        end
        wr(`AIS_IRQ_MASK_OFS, 32'h1);
        for (int m = 0; m <= int'(ais_pkg::AIS_SCAN_CONT); m++) begin
            wr(`AIS_IRQ_STAT_OFS, 32'h7);
            level <= 10'($urandom());
            wr(`AIS_CTRL_OFS, 32'h21 | 32'(m << 2));
            wait_irq(3 * CC);
            chk("std_channel", (m >= 2) ? 32'h1 : 32'h2, {28'h0, conv_channel});
            rd(`AIS_STD_RES_OFS);
            chk("std_res", {16'h0, 4'h2, 2'h0, level}, d);
            rd(`AIS_CTRL_OFS);
            chk("run_bit", 32'h20 | 32'(m << 2) | 32'(m != 0), d);
            wr(`AIS_CTRL_OFS, 32'h0);
        end
        wr(`AIS_IRQ_STAT_OFS, 32'h7);
        wr(`AIS_IRQ_MASK_OFS, 32'h2);
        wr(`AIS_CTRL_OFS, 32'h500);
        level <= 10'($urandom());
        u_trig.fire();
        rd(`AIS_CTRL_OFS);
        chk("pend_set", 32'h502, d);
        rd(`AIS_IRQ_STAT_OFS);
        chk("trig_flag", 32'h4, d);
        wr(`AIS_CTRL_OFS, 32'h500);
        rd(`AIS_STATUS_OFS);
        chk("latch", 32'h2, d);
        chk("inj_channel", 32'h5, {28'h0, conv_channel});
        wait_irq(3 * CC);
        rd(`AIS_INJ_RES_OFS);
        chk("inj_res", {16'h0, 4'h5, 2'h0, level}, d);
        rd(`AIS_IRQ_STAT_OFS);
        chk("inj_flags", 32'h6, d);
        wr(`AIS_IRQ_STAT_OFS, 32'h6);
        repeat (2) @(posedge ref_clk);
        #1 chk("irq_low", 32'h0, {31'h0, irq});
        // Software sees the pending bit and defers its start to the end of injection
        u_trig.fire();
        rd(`AIS_CTRL_OFS);
        chk("pend_seen", 32'h502, d);
        wait_irq(3 * CC);
        wr(`AIS_IRQ_STAT_OFS, 32'h7);
        wr(`AIS_IRQ_MASK_OFS, 32'h1);
        rd(`AIS_CTRL_OFS);
        chk("pend_gone", 32'h500, d);
        if (d[`AIS_CTRL_PEND] == 1'b0) begin
            wr(`AIS_CTRL_OFS, 32'h531);
        end
        wait_irq(3 * CC);
        rd(`AIS_STD_RES_OFS);
        chk("std_deferred", {16'h0, 4'h3, 2'h0, level}, d);
        wr(`AIS_IRQ_STAT_OFS, 32'h7);
        // Start one cycle before the window: injection survives, start is deferred
        wr(`AIS_IRQ_MASK_OFS, 32'h3);
        level <= 10'($urandom());
        inj_start(CC - 2, 32'h531);
        exp_res.push_back({16'h0, 4'h5, 2'h0, level});
        exp_res.push_back({16'h0, 4'h3, 2'h0, level});
        wait_irq(3 * CC);
        rd(`AIS_INJ_RES_OFS);
        kept = d;
        chk("inj_kept", exp_res.pop_front(), d);
        wr(`AIS_IRQ_STAT_OFS, 32'h6);
        wait_irq(3 * CC);
        rd(`AIS_STD_RES_OFS);
        chk("std_after", exp_res.pop_front(), d);
        wr(`AIS_IRQ_STAT_OFS, 32'h7);
        // Start taken in the final injection cycle locks the converter
        level <= level ^ 10'h3ff;
        inj_start(CC - 1, 32'h531);
        repeat (3 * CC) @(posedge ref_clk);
        rd(`AIS_INJ_RES_OFS);
        chk("inj_lost", kept, d);
        rd(`AIS_IRQ_STAT_OFS);
        chk("no_done", 32'h4, d);
        rd(`AIS_STATUS_OFS);
        chk("blocked", 32'h4, d & 32'h5);
        wr(`AIS_IRQ_STAT_OFS, 32'h7);
        u_trig.fire();
        repeat (CC) @(posedge ref_clk);
        rd(`AIS_IRQ_STAT_OFS);
        chk("refused", 32'h0, d);
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        rd(`AIS_STATUS_OFS);
        chk("unblocked", 32'h0, d);
        complete_run();
    end
endmodule : ais_sequencer_tb

// ==== dv/ais_trig_model.sv ====
// Purpose: Trigger channel and converter core stand-in for the sequencer bench
// Assumes: Requests and samples live on ref_clk
// Notes:   Sample is held steady by the bench across each conversion
`timescale 1ns/10ps
module ais_trig_model (
    input  wire logic       ref_clk,
    input  wire logic [9:0] level,
    output logic            inj_req,
    output logic [9:0]      conv_sample
);
    assign conv_sample = level;
    initial inj_req = 1'b0;
    // One-cycle request launched just after an edge, never merged with the next
    task automatic fire();
        @(posedge ref_clk);
        inj_req <= 1'b1;
        @(posedge ref_clk);
        inj_req <= 1'b0;
    endtask : fire
endmodule : ais_trig_model

// ==== verilog/ais_defines.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the injection sequencer
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes:   Definitions only
`ifndef AIS_DEFINES_SVH
`define AIS_DEFINES_SVH
// ****************************************
// Register offsets
// ****************************************
`define AIS_CTRL_OFS      8'h00
`define AIS_STATUS_OFS    8'h04
`define AIS_STD_RES_OFS   8'h08
`define AIS_INJ_RES_OFS   8'h0c
`define AIS_IRQ_STAT_OFS  8'h10
`define AIS_IRQ_MASK_OFS  8'h14
// ****************************************
// Control fields
// ****************************************
`define AIS_CTRL_START    0
`define AIS_CTRL_PEND     1
`define AIS_CTRL_MODE_LO  2
`define AIS_CTRL_CH_LO    4
`define AIS_CTRL_ICH_LO   8
// ****************************************
// Interrupt status bits and reset values
// ****************************************
`define AIS_IRQ_STD       0
`define AIS_IRQ_INJ       1
`define AIS_IRQ_TRIG      2
`define AIS_IRQ_RST       3'h0
`define AIS_MASK_RST      3'h0
// ****************************************
// Timing
// ****************************************
`define AIS_CLK_NS        50
`define AIS_TCL_NS        25
`define AIS_HAZ_TCL       2
`define AIS_HAZ_CYC       (((`AIS_HAZ_TCL * `AIS_TCL_NS) + `AIS_CLK_NS - 1) / `AIS_CLK_NS)
`define AIS_CONV_CYC      16
`endif

// ==== verilog/ais_pkg.sv ====
// Purpose: Types of the injection sequencer
// Assumes: Constants live in ais_defines.svh
// Notes:   One-hot sequencer states
package ais_pkg;
    typedef enum logic [3:0] {
        AIS_IDLE    = 4'h1,
        AIS_STD     = 4'h2,
        AIS_INJ     = 4'h4,
        AIS_BLOCKED = 4'h8
    } ais_state_t;

    typedef enum logic [1:0] {
        AIS_SINGLE      = 2'h0,
        AIS_SINGLE_CONT = 2'h1,
        AIS_SCAN        = 2'h2,
        AIS_SCAN_CONT   = 2'h3
    } ais_mode_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } ais_bus_t;
endpackage : ais_pkg

// ==== verilog/ais_sequencer.sv ====
// Purpose: Conversion sequencer of the A/D converter, standard and injected
// Assumes: ref_clk 20 MHz, trigger pulse from logic on ref_clk, sample from core
// Notes:   Keeps the known stepping fault around the end of an injection
//
// Notes on behaviour
// - Software starts single, scan or continuous conversions
// - Start near injection end loses injected result
// - That hazard blocks converter, no more work
// - Normal injection end stores result, raises flag
// - Injection request sets pending and trigger flag
// - Pending bit unprotected during control writes
// - Hidden latch runs injections, not pending bit
// - Standard start aborts running injection only in its last cycle
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`include "ais_defines.svh"

module ais_sequencer #(
    parameter int DW       = 10,
    parameter int CONV_CYC = `AIS_CONV_CYC
) (
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire ais_pkg::ais_bus_t bus,
    output logic [31:0]            rdata,
    input  wire logic              inj_req,
    input  wire logic [DW-1:0]     conv_sample,
    output logic [3:0]             conv_channel,
    output logic                   irq
);
    localparam logic [7:0] HAZ   = 8'(`AIS_HAZ_CYC);
    localparam logic [7:0] CLAST = 8'(CONV_CYC - 1);

    ais_pkg::ais_state_t state,      next_state;
    logic [7:0]          cnt,        next_cnt;
    logic                run,        next_run;
    logic                pend,       next_pend;
    logic                inj_latch,  next_inj_latch;
    ais_pkg::ais_mode_t  mode,       next_mode;
    logic [3:0]          std_ch,     next_std_ch;
    logic [3:0]          scan_ch,    next_scan_ch;
    logic [3:0]          inj_ch,     next_inj_ch;
    logic [15:0]         std_res,    next_std_res;
    logic [15:0]         inj_res,    next_inj_res;
    logic [2:0]          irq_stat,   next_irq_stat;
    logic [2:0]          irq_mask,   next_irq_mask;
    logic [31:0]         next_rdata;

    logic ctrl_wr;
    logic start_wr;
    logic conv_end;

    assign ctrl_wr  = bus.wr && (bus.addr == `AIS_CTRL_OFS);
    assign start_wr = ctrl_wr && bus.wdata[`AIS_CTRL_START];
    assign conv_end = (cnt == 8'h00);

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        next_state     = state;
        next_cnt       = conv_end ? cnt : cnt - 8'h01;
        next_run       = run;
        next_pend      = pend;
        next_inj_latch = inj_latch;
        next_mode      = mode;
        next_std_ch    = std_ch;
        next_scan_ch   = scan_ch;
        next_inj_ch    = inj_ch;
        next_std_res   = std_res;
        next_inj_res   = inj_res;
        next_irq_stat  = irq_stat;
        next_irq_mask  = irq_mask;
        if (bus.wr && bus.addr == `AIS_IRQ_STAT_OFS) begin
            next_irq_stat = irq_stat & ~bus.wdata[2:0];
        end
        if (bus.wr && bus.addr == `AIS_IRQ_MASK_OFS) begin
            next_irq_mask = bus.wdata[2:0];
        end
        if (ctrl_wr) begin
            // Plain write of the whole word: a request landing earlier in the
            // same read-modify-write is lost from the visible bit
            next_pend   = bus.wdata[`AIS_CTRL_PEND];
            next_run    = bus.wdata[`AIS_CTRL_START];
            next_mode   = ais_pkg::ais_mode_t'(bus.wdata[`AIS_CTRL_MODE_LO +: 2]);
            next_std_ch = bus.wdata[`AIS_CTRL_CH_LO +: 4];
            next_inj_ch = bus.wdata[`AIS_CTRL_ICH_LO +: 4];
            if (start_wr && !run) begin
                next_scan_ch = bus.wdata[`AIS_CTRL_CH_LO +: 4];
            end
        end
        case (state)
            ais_pkg::AIS_IDLE: begin
                if (inj_latch) begin
                    next_state = ais_pkg::AIS_INJ;
                    next_cnt   = CLAST;
                end else if (run) begin
                    next_state = ais_pkg::AIS_STD;
                    next_cnt   = CLAST;
                end
            end
            ais_pkg::AIS_STD: begin
                if (conv_end) begin
                    next_std_res                = {scan_ch, 2'h0, 10'(conv_sample)};
                    next_irq_stat[`AIS_IRQ_STD] = 1'b1;
                    next_cnt                    = CLAST;
                    if (mode[1] && scan_ch != 4'h0) begin
                        next_scan_ch = scan_ch - 4'h1;
                    end else begin
                        next_scan_ch = std_ch;
                        if (!mode[0]) begin
                            next_run = 1'b0;
                        end
                    end
                    if (inj_latch) begin
                        next_state = ais_pkg::AIS_INJ;
                    end else if (!(next_run && run)) begin
                        next_state = ais_pkg::AIS_IDLE;
                    end
                end else if (!run) begin
                    next_state = ais_pkg::AIS_IDLE;
                end
            end
            ais_pkg::AIS_INJ: begin
                // A late start wedges the converter; an early one only waits
                if (start_wr && cnt < HAZ) begin
                    next_state = ais_pkg::AIS_BLOCKED;
                end else if (conv_end) begin
                    next_inj_res                = {inj_ch, 2'h0, 10'(conv_sample)};
                    next_irq_stat[`AIS_IRQ_INJ] = 1'b1;
                    next_inj_latch              = 1'b0;
                    next_pend                   = 1'b0;
                    next_cnt                    = CLAST;
                    next_state = next_run ? ais_pkg::AIS_STD : ais_pkg::AIS_IDLE;
                end
            end
            ais_pkg::AIS_BLOCKED: begin
                next_state = ais_pkg::AIS_BLOCKED;
            end
            default: begin
                next_state = ais_pkg::AIS_IDLE;
            end
        endcase
        // Hardware set wins over a software clear in the same cycle
        if (inj_req && state != ais_pkg::AIS_BLOCKED) begin
            next_pend                    = 1'b1;
            next_irq_stat[`AIS_IRQ_TRIG] = 1'b1;
            next_inj_latch               = 1'b1;
        end
    end

    // ****************************************
    // Register read
    // ****************************************
    always_comb begin
        next_rdata = 32'h0;
        if (bus.rd) begin
            case (bus.addr)
                `AIS_CTRL_OFS:     next_rdata = {20'h0, inj_ch, std_ch, mode, pend, run};
                `AIS_STATUS_OFS:   next_rdata = {29'h0, state == ais_pkg::AIS_BLOCKED, inj_latch,
                                                 state == ais_pkg::AIS_STD};
                `AIS_STD_RES_OFS:  next_rdata = {16'h0, std_res};
                `AIS_INJ_RES_OFS:  next_rdata = {16'h0, inj_res};
                `AIS_IRQ_STAT_OFS: next_rdata = {29'h0, irq_stat};
                `AIS_IRQ_MASK_OFS: next_rdata = {29'h0, irq_mask};
                default:           next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state        <= ais_pkg::AIS_IDLE;
            cnt          <= 8'h00;
            run          <= 1'b0;
            pend         <= 1'b0;
            inj_latch    <= 1'b0;
            mode         <= ais_pkg::AIS_SINGLE;
            std_ch       <= 4'h0;
            scan_ch      <= 4'h0;
            inj_ch       <= 4'h0;
            std_res      <= 16'h0;
            inj_res      <= 16'h0;
            irq_stat     <= `AIS_IRQ_RST;
            irq_mask     <= `AIS_MASK_RST;
            rdata        <= 32'h0;
            conv_channel <= 4'h0;
            irq          <= 1'b0;
        end else begin
            state        <= next_state;
            cnt          <= next_cnt;
            run          <= next_run;
            pend         <= next_pend;
            inj_latch    <= next_inj_latch;
            mode         <= next_mode;
            std_ch       <= next_std_ch;
            scan_ch      <= next_scan_ch;
            inj_ch       <= next_inj_ch;
            std_res      <= next_std_res;
            inj_res      <= next_inj_res;
            irq_stat     <= next_irq_stat;
            irq_mask     <= next_irq_mask;
            rdata        <= next_rdata;
            conv_channel <= (next_state == ais_pkg::AIS_INJ) ? next_inj_ch : next_scan_ch;
            irq          <= |(next_irq_stat & next_irq_mask);
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    wire inj_last = (state == ais_pkg::AIS_INJ) && conv_end;

    hazard_no_store_a: assert property (
        (state == ais_pkg::AIS_INJ && start_wr && cnt < HAZ)
            |=> $stable(inj_res) && state == ais_pkg::AIS_BLOCKED)
        else $error("late start stored injected result");

    blocked_stays_a: assert property (
        state == ais_pkg::AIS_BLOCKED |=> (state == ais_pkg::AIS_BLOCKED && $stable(inj_res)) [*4])
        else $error("blocked converter resumed");

    inj_done_flag_a: assert property (
        (inj_last && !start_wr && !(bus.wr && bus.addr == `AIS_IRQ_STAT_OFS))
            |=> irq_stat[`AIS_IRQ_INJ] && inj_res[DW-1:0] == $past(conv_sample))
        else $error("injection end not recorded");

    req_sets_both_a: assert property (
        (inj_req && state != ais_pkg::AIS_BLOCKED) |=> pend && irq_stat[`AIS_IRQ_TRIG] && inj_latch)
        else $error("request did not set pending and trigger flag");

    pend_clear_wr_a: assert property (
        (ctrl_wr && !bus.wdata[`AIS_CTRL_PEND] && !inj_req) |=> !pend)
        else $error("control write did not overwrite pending bit");

    latch_kept_a: assert property (
        (inj_latch && ctrl_wr && !inj_last) |=> inj_latch)
        else $error("control write disturbed injection latch");

    no_abort_a: assert property (
        (state == ais_pkg::AIS_INJ && start_wr && cnt >= HAZ)
            |=> state == ais_pkg::AIS_INJ ##[1:300] state != ais_pkg::AIS_INJ && irq_stat[`AIS_IRQ_INJ])
        else $error("standard start aborted injection");

    idle_start_a: assert property (
        (state == ais_pkg::AIS_IDLE && run && !inj_latch) |=> state == ais_pkg::AIS_STD [*2])
        else $error("software start did not begin conversion");

    irq_level_a: assert property (
        irq == $past(|(next_irq_stat & next_irq_mask)))
        else $error("interrupt output wrong");

    inj_cover_c:     cover property (inj_last ##1 state == ais_pkg::AIS_STD);
    hazard_cover_c:  cover property (state == ais_pkg::AIS_BLOCKED);
    scan_cover_c:    cover property (state == ais_pkg::AIS_STD && mode == ais_pkg::AIS_SCAN_CONT && conv_end);
    deferred_cover_c: cover property (state == ais_pkg::AIS_INJ && start_wr && cnt >= HAZ);

endmodule : ais_sequencer
